// >>> scc_consts.svh
// Named offsets, bit positions, reset values and divider counts for the
// serial channel control block. Assumes inclusion by bare name.
`ifndef SCC_CONSTS_SVH
`define SCC_CONSTS_SVH

`define SCC_OFS_CTRL 8'h00
`define SCC_OFS_RXDATA 8'h04
`define SCC_OFS_STATUS 8'h08

`define SCC_CTRL_RESET 16'h0000
`define SCC_MODE_HI 2
`define SCC_MODE_LO 0
`define SCC_BIT_STOP 3
`define SCC_BIT_REN 4
`define SCC_BIT_PEN 5
`define SCC_BIT_FEN 6
`define SCC_BIT_OEN 7
`define SCC_BIT_PERR 8
`define SCC_BIT_FERR 9
`define SCC_BIT_OERR 10
`define SCC_BIT_FDE 11
`define SCC_BIT_ODD 12
`define SCC_BIT_BRS 13
`define SCC_BIT_LB 14
`define SCC_BIT_RUN 15
`define SCC_BIT_PARITY 8

`define SCC_DIV2_LAST 2'h1
`define SCC_DIV3_LAST 2'h2
`define SCC_BUF_DEPTH 2
`define SCC_RX_WIDTH 9

`endif

// >>> scc_pkg.sv
// Types shared by the serial channel control block.
// Assumes scc_consts.svh supplies the numeric constants.
package scc_pkg;

  // Frame format selected by the three-bit mode field
  typedef enum logic [2:0] {
    SCC_SYNC8 = 3'b000,
    SCC_ASYNC8 = 3'b001,
    SCC_IRDA8 = 3'b010,
    SCC_ASYNC7P = 3'b011,
    SCC_ASYNC9 = 3'b100,
    SCC_ASYNC8W = 3'b101,
    SCC_RSVD6 = 3'b110,
    SCC_ASYNC8P = 3'b111
  } scc_mode_t;

endpackage : scc_pkg

// >>> scc_rx_buffer.sv
// Two-entry receive buffer with valid/ready on both sides.
// Assumes one clock, asynchronous active-high reset and a clock enable.
`timescale 1ns/100ps
`include "scc_consts.svh"

module scc_rx_buffer #(
  parameter int WIDTH = `SCC_RX_WIDTH,
  parameter int DEPTH = `SCC_BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH+1)-1:0] level
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_reg;
  logic [PW-1:0] rdPtr_reg;
  logic [CW-1:0] count_reg;
  wire push = ce && inValid && inReady;
  wire pop = ce && outValid && outReady;

  // Full and empty come straight from the count, so the source really stalls
  assign inReady = (count_reg != CW'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData = mem[rdPtr_reg];
  assign level = count_reg;

  // Storage has no reset; only the pointers and the count carry control state
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  // Pointers wrap at the depth, count tracks push minus pop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= (wrPtr_reg == PW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == PW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule : scc_rx_buffer

// >>> scc_serial_channel_control.sv
// Control register, error flags, receive buffer and baud prescaler of a
// serial channel, reached over APB.
// Assumes a receiver core that reports each finished frame with a pulse,
// an autobaud unit that reports detections, and a fractional divider tick.
//
// Behaviour
// - Mode bits 2..0 select sync 8-bit (000), async 8-bit (001) or IrDA 8-bit (010).
// - Mode also selects 7+parity (011), 9-bit (100), 8+wake-up (101), 8+parity (111).
// - A successful autobaud detection overwrites the mode field and the parity polarity.
// - Bit 3 gives one stop bit when 0 and two stop bits when 1.
// - Bit 4 gates reception and is cleared by hardware after a sync byte is received.
// - The autobaud unit may change bit 4 only while its automatic receiver option is on.
// - Outside IrDA, bit 5 enables the parity check; when 0 parity is ignored.
// - In IrDA mode bit 5 instead inverts the receive data input.
// - A parity error with the check on sets the sticky flag at bit 8.
// - An async framing error with bit 6 on sets the sticky flag at bit 9.
// - An overrun with bit 7 on sets the sticky flag at bit 10.
// - Bit 11 selects the fractional divider as prescaler and masks bit 13.
// - Bit 12 clear means even parity, set means odd parity.
// - Bit 13 picks a divide-by-2 prescaler when 0 and divide-by-3 when 1.
// - Bit 15 runs the baud generator; when 0 the prescaled clock stays inactive.
`timescale 1ns/100ps
`include "scc_consts.svh"

module scc_serial_channel_control (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receiver core
  input wire logic rxdPin,
  output logic rxdToCore,
  input wire logic rxFrameDone,
  input wire logic [8:0] rxFrameData,
  input wire logic rxStopBad,
  output logic rxFrameReady,
  // Autobaud unit
  input wire logic autobaudOn,
  input wire logic autoRxCtl,
  input wire logic abDetectOk,
  input wire logic [2:0] abMode,
  input wire logic abOdd,
  input wire logic abRenWrite,
  input wire logic abRenValue,
  // Baud generator
  input wire logic fracTick,
  output logic prescaledBaudClk,
  // Decoded controls for the transmit and receive cores
  output logic [2:0] frameMode,
  output logic stopBitCount,
  output logic rxEnable,
  output logic oddParity,
  output logic loopBackOn
);

  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic rxdInv_reg;
  logic tick_reg;
  logic [1:0] divCnt_reg;
  logic [1:0] divCnt_next;
  logic bufValid;
  logic [8:0] bufData;
  logic [1:0] bufLevel;

  // APB decode; the slave answers in the access cycle unless ce is low
  wire apbAccess = psel && penable && ce;
  wire selCtrl = (paddr == `SCC_OFS_CTRL);
  wire selRxData = (paddr == `SCC_OFS_RXDATA);
  wire selStatus = (paddr == `SCC_OFS_STATUS);
  wire selAny = selCtrl || selRxData || selStatus;
  wire ctrlWr = apbAccess && pwrite && selCtrl;
  wire rxPop = apbAccess && !pwrite && selRxData;
  assign pready = ce;
  assign pslverr = psel && penable && !selAny;

  // Field views of the control register
  wire [2:0] modeBits = ctrl_reg[`SCC_MODE_HI:`SCC_MODE_LO];
  wire renBit = ctrl_reg[`SCC_BIT_REN];
  wire penBit = ctrl_reg[`SCC_BIT_PEN];
  wire fenBit = ctrl_reg[`SCC_BIT_FEN];
  wire oenBit = ctrl_reg[`SCC_BIT_OEN];
  wire fdeBit = ctrl_reg[`SCC_BIT_FDE];
  wire oddBit = ctrl_reg[`SCC_BIT_ODD];
  wire brsBit = ctrl_reg[`SCC_BIT_BRS];
  wire runBit = ctrl_reg[`SCC_BIT_RUN];

  // Mode classes
  wire isSync = (modeBits == scc_pkg::SCC_SYNC8);
  wire isIrda = (modeBits == scc_pkg::SCC_IRDA8);
  wire is7Par = (modeBits == scc_pkg::SCC_ASYNC7P);
  wire is8Par = (modeBits == scc_pkg::SCC_ASYNC8P);
  wire hasParity = is7Par || is8Par;

  // Parity of the received data; 7-bit frames leave bit 7 out
  wire [7:0] parData = is7Par ? {1'b0, rxFrameData[6:0]} : rxFrameData[7:0];
  wire expParity = (^parData) ^ oddBit;
  wire gotParity = rxFrameData[`SCC_BIT_PARITY];

  // A frame only counts while the receiver is enabled
  wire frameIn = ce && rxFrameDone && renBit;
  wire bufInReady;
  wire parityEvt = frameIn && penBit && !isIrda && hasParity
    && (expParity != gotParity);
  wire framingEvt = frameIn && fenBit && !isSync && rxStopBad;
  wire overrunEvt = frameIn && oenBit && !bufInReady;
  wire abRenOk = abRenWrite && autobaudOn && autoRxCtl;

  // Error flag update: a zero written clears, hardware set wins over it
  function automatic logic flagNext(input logic cur, input logic wrOn,
                                    input logic wrBit, input logic evt);
    logic keep;
    keep = cur && !(wrOn && !wrBit);
    flagNext = keep || evt;
  endfunction : flagNext

  // Next control value; autobaud overwrite takes priority over software
  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrlWr) begin
      ctrl_next = pwdata[15:0];
      ctrl_next[`SCC_BIT_PERR] = ctrl_reg[`SCC_BIT_PERR];
      ctrl_next[`SCC_BIT_FERR] = ctrl_reg[`SCC_BIT_FERR];
      ctrl_next[`SCC_BIT_OERR] = ctrl_reg[`SCC_BIT_OERR];
    end
    if (abDetectOk) begin
      ctrl_next[`SCC_MODE_HI:`SCC_MODE_LO] = abMode;
      ctrl_next[`SCC_BIT_ODD] = abOdd;
    end
    if (abRenOk) begin
      ctrl_next[`SCC_BIT_REN] = abRenValue;
    end
    if (frameIn && isSync) begin
      ctrl_next[`SCC_BIT_REN] = 1'b0;
    end
    ctrl_next[`SCC_BIT_PERR] = flagNext(ctrl_reg[`SCC_BIT_PERR], ctrlWr,
                                        pwdata[`SCC_BIT_PERR], parityEvt);
    ctrl_next[`SCC_BIT_FERR] = flagNext(ctrl_reg[`SCC_BIT_FERR], ctrlWr,
                                        pwdata[`SCC_BIT_FERR], framingEvt);
    ctrl_next[`SCC_BIT_OERR] = flagNext(ctrl_reg[`SCC_BIT_OERR], ctrlWr,
                                        pwdata[`SCC_BIT_OERR], overrunEvt);
  end

  // Control register, frozen while ce is low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= `SCC_CTRL_RESET;
    end else if (ce) begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Receive input path; the inverter only acts in IrDA mode
  wire rxdInvOn = isIrda && penBit;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxdInv_reg <= 1'b0;
    end else if (ce) begin
      rxdInv_reg <= rxdPin ^ rxdInvOn;
    end
  end
  assign rxdToCore = rxdInv_reg;

  // Baud prescaler: fractional tick, or a divide-by-2 / divide-by-3 count
  wire [1:0] divLast = brsBit ? `SCC_DIV3_LAST : `SCC_DIV2_LAST;
  wire divWrap = (divCnt_reg == divLast);
  wire tickNext = runBit && (fdeBit ? fracTick : divWrap);
  assign divCnt_next = (!runBit || fdeBit || divWrap) ? 2'h0 : divCnt_reg + 2'h1;

  // The count restarts whenever the generator stops, so the first period is whole
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divCnt_reg <= 2'h0;
      tick_reg <= 1'b0;
    end else if (ce) begin
      divCnt_reg <= divCnt_next;
      tick_reg <= tickNext;
    end
  end
  assign prescaledBaudClk = tick_reg;

  // Received frames queue here, two deep, so a software read one frame late loses no word
  scc_rx_buffer #(
    .WIDTH(`SCC_RX_WIDTH),
    .DEPTH(`SCC_BUF_DEPTH)
  ) u_rxbuf (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .inValid(rxFrameDone && renBit),
    .inReady(bufInReady),
    .inData(rxFrameData),
    .outValid(bufValid),
    .outReady(rxPop),
    .outData(bufData),
    .level(bufLevel)
  );
  assign rxFrameReady = bufInReady;

  // Read data selection; an empty buffer reads as zero
  wire [31:0] rdCtrl = {16'h0000, ctrl_reg};
  wire [31:0] rdRx = bufValid ? {23'h000000, bufData} : 32'h00000000;
  wire [31:0] rdStat = {29'h00000000, bufInReady, bufLevel};
  assign prdata = selCtrl ? rdCtrl : (selRxData ? rdRx : (selStatus ? rdStat : 32'h0));

  // Decoded controls
  assign frameMode = modeBits;
  assign stopBitCount = ctrl_reg[`SCC_BIT_STOP];
  assign rxEnable = renBit;
  assign oddParity = oddBit;
  assign loopBackOn = ctrl_reg[`SCC_BIT_LB];

  // Checks on the register behaviour
  sequence sSyncByte;
    ce && rxFrameDone && renBit && isSync;
  endsequence

  sequence sClearPerr;
    ce && ctrlWr && !pwdata[`SCC_BIT_PERR] && !parityEvt;
  endsequence

  mode_write_a: assert property (@(posedge clk) disable iff (rst)
    ce && ctrlWr && !abDetectOk |=> frameMode == $past(pwdata[2:0]))
    else $error("mode field did not take the written value");

  ab_overwrite_a: assert property (@(posedge clk) disable iff (rst)
    ce && abDetectOk |=> frameMode == $past(abMode) && oddParity == $past(abOdd))
    else $error("autobaud result not loaded into mode and parity polarity");

  stop_write_a: assert property (@(posedge clk) disable iff (rst)
    ce && ctrlWr |=> stopBitCount == $past(pwdata[`SCC_BIT_STOP]))
    else $error("stop bit count did not follow write");

  sync_ren_clear_a: assert property (@(posedge clk) disable iff (rst)
    sSyncByte |=> !rxEnable)
    else $error("receiver enable not cleared after sync byte");

  irda_invert_a: assert property (@(posedge clk) disable iff (rst)
    ce |=> rxdToCore == ($past(rxdPin) ^ $past(isIrda && penBit)))
    else $error("receive input inversion wrong");

  parity_sticky_a: assert property (@(posedge clk) disable iff (rst)
    ce && parityEvt |=> ctrl_reg[`SCC_BIT_PERR] ##1 ctrl_reg[`SCC_BIT_PERR] || $past(ctrlWr))
    else $error("parity error flag not set or not held");

  framing_set_a: assert property (@(posedge clk) disable iff (rst)
    ce && rxFrameDone && renBit && fenBit && rxStopBad && !isSync
    |=> ctrl_reg[`SCC_BIT_FERR])
    else $error("framing error flag not set");

  overrun_set_a: assert property (@(posedge clk) disable iff (rst)
    ce && rxFrameDone && renBit && oenBit && !rxFrameReady
    |=> ctrl_reg[`SCC_BIT_OERR])
    else $error("overrun flag not set on full buffer");

  gen_stopped_a: assert property (@(posedge clk) disable iff (rst)
    ce && !runBit |=> !prescaledBaudClk)
    else $error("prescaled clock active while generator stopped");

  div3_spacing_a: assert property (@(posedge clk) disable iff (rst)
    ce && prescaledBaudClk && runBit && !fdeBit && brsBit && !ctrlWr
    ##1 ce && !ctrlWr |-> !prescaledBaudClk)
    else $error("divide-by-3 ticks too close");

  frac_select_a: assert property (@(posedge clk) disable iff (rst)
    ce && runBit && fdeBit |=> prescaledBaudClk == $past(fracTick))
    else $error("fractional divider tick not passed through");

  flag_clear_a: assert property (@(posedge clk) disable iff (rst)
    sClearPerr |=> !ctrl_reg[`SCC_BIT_PERR])
    else $error("writing zero did not clear parity error flag");

  // With the check off the parity flag can only change through a software write
  parity_off_a: assert property (@(posedge clk) disable iff (rst)
    ce && !penBit && !ctrlWr |=> ctrl_reg[`SCC_BIT_PERR] == $past(ctrl_reg[`SCC_BIT_PERR]))
    else $error("parity flag changed with parity check off");

  // Whole nine-bit frame parity against the polarity bit, written out independently
  odd_parity_a: assert property (@(posedge clk) disable iff (rst)
    ce && rxFrameDone && renBit && penBit && is8Par && ((^rxFrameData) != oddBit)
    |=> ctrl_reg[`SCC_BIT_PERR])
    else $error("parity polarity not applied to the check");

  // Autobaud writes of the enable are ignored without the automatic option
  ab_ren_gate_a: assert property (@(posedge clk) disable iff (rst)
    ce && abRenWrite && !(autobaudOn && autoRxCtl) && !ctrlWr && !(frameIn && isSync)
    |=> rxEnable == $past(rxEnable))
    else $error("receiver enable changed by autobaud without option");

  // A low clock enable freezes the register and the baud tick
  ce_freeze_a: assert property (@(posedge clk) disable iff (rst)
    !ce |=> ctrl_reg == $past(ctrl_reg) && prescaledBaudClk == $past(prescaledBaudClk))
    else $error("state changed while clock enable low");

endmodule : scc_serial_channel_control

// >>> scc_peer_model.sv
// Far-side peer as seen through the receiver core: reports finished frames.
// Assumes the caller enters send just after a rising edge, one frame at a time.
`timescale 1ns/100ps

module scc_peer_model (
  input wire logic clk,
  output logic rxFrameDone,
  output logic [8:0] rxFrameData,
  output logic rxStopBad
);
  // Idle lines carry inverted values so a stale frame never looks valid
  initial begin
    rxFrameDone = 1'b0;
    rxFrameData = 9'h0aa;
    rxStopBad = 1'b1;
  end

  // Optional idle gap (slow peer), one-cycle done pulse, then release
  task automatic send(input logic [8:0] d, input logic bad, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    rxFrameDone <= 1'b1;
    rxFrameData <= d;
    rxStopBad <= bad;
    @(posedge clk);
    rxFrameDone <= 1'b0;
    rxFrameData <= ~d;
    rxStopBad <= ~bad;
  endtask : send
endmodule : scc_peer_model

// >>> scc_serial_channel_control_bench.sv
// Self-checking bench for the serial channel control block.
// Assumes the APB slave answers with pready and the peer model feeds frames.
`timescale 1ns/100ps
`include "scc_consts.svh"

module scc_serial_channel_control_bench;
  localparam logic [7:0] CTRL_A = `SCC_OFS_CTRL;
  localparam logic [7:0] RXD_A = `SCC_OFS_RXDATA;
  localparam logic [7:0] STS_A = `SCC_OFS_STATUS;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rerr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic rxdPin = 1'b1, rxdToCore, rxFrameDone, rxStopBad, rxFrameReady;
  logic [8:0] rxFrameData;
  logic autobaudOn = 1'b0, autoRxCtl = 1'b0, abDetectOk = 1'b0, abOdd = 1'b0;
  logic abRenWrite = 1'b0, abRenValue = 1'b0, fracTick = 1'b0, prescaledBaudClk;
  logic [2:0] abMode = 3'h0, frameMode;
  logic stopBitCount, rxEnable, oddParity, loopBackOn;
  int bad_count = 0;
  int check_count = 0;
  // Rows: write value, then expected readback; flags cannot be set by software
  logic [63:0] rows [7] = '{64'h00000001_00000001, 64'h00000002_00000002,
    64'hffff0003_00000003, 64'h0000070c_0000000c, 64'h000010f5_000010f5,
    64'h00006007_00006007, 64'h00008818_00008818};

  scc_serial_channel_control i_scc_serial_channel_control (.clk(clk), .rst(rst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxdPin(rxdPin),
    .rxdToCore(rxdToCore), .rxFrameDone(rxFrameDone), .rxFrameData(rxFrameData),
    .rxStopBad(rxStopBad), .rxFrameReady(rxFrameReady), .autobaudOn(autobaudOn),
    .autoRxCtl(autoRxCtl), .abDetectOk(abDetectOk), .abMode(abMode), .abOdd(abOdd),
    .abRenWrite(abRenWrite), .abRenValue(abRenValue), .fracTick(fracTick),
    .prescaledBaudClk(prescaledBaudClk), .frameMode(frameMode),
    .stopBitCount(stopBitCount), .rxEnable(rxEnable), .oddParity(oddParity),
    .loopBackOn(loopBackOn));

  scc_peer_model i_scc_peer_model (.clk(clk), .rxFrameDone(rxFrameDone),
    .rxFrameData(rxFrameData), .rxStopBad(rxStopBad));

  // 25 MHz clock
  always #20 clk = ~clk;

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; an idle edge first keeps psel from toggling in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin
      bad_count++;
      stop_test();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rdata, e);
  endtask : rchk

  // Counts baud ticks over 12 cycles while the fractional tick pulses every 4
  task automatic ticks(input logic [31:0] c, input int exp);
    int n = 0;
    apb(1'b1, CTRL_A, c);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      fracTick <= (i % 4 == 0);
      if (i >= 4 && prescaledBaudClk === 1'b1) n++;
    end
    chk("ticks", 32'(n), 32'(exp));
  endtask : ticks

  // Autobaud write of the receiver enable, with the automatic option as given
  task automatic abren(input logic ctl);
    @(posedge clk);
    autoRxCtl <= ctl;
    abRenWrite <= 1'b1;
    abRenValue <= 1'b1;
    @(posedge clk);
    abRenWrite <= 1'b0;
  endtask : abren

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rchk("ctrl", CTRL_A, 32'h0);
    chk("room", 32'(rxFrameReady), 32'h1);
    $display("reset test done");
    foreach (rows[k]) begin
      apb(1'b1, CTRL_A, rows[k][63:32]);
      rchk("ctrl", CTRL_A, rows[k][31:0]);
      chk("fields", 32'({loopBackOn, oddParity, rxEnable, stopBitCount, frameMode}),
        32'({rows[k][14], rows[k][12], rows[k][4], rows[k][3], rows[k][2:0]}));
    end
    $display("table test done");
    apb(1'b1, CTRL_A, 32'h00f7);
    i_scc_peer_model.send(9'h035, 1'b0, 0);
    i_scc_peer_model.send(9'h135, 1'b0, 3);
    rchk("ctrl", CTRL_A, 32'h01f7);
    rchk("rx", RXD_A, 32'h035);
    rchk("rx", RXD_A, 32'h135);
    rchk("rx", RXD_A, 32'h000);
    apb(1'b1, CTRL_A, 32'h01f7);
    rchk("ctrl", CTRL_A, 32'h01f7);
    apb(1'b1, CTRL_A, 32'h10f7);
    i_scc_peer_model.send(9'h135, 1'b0, 0);
    i_scc_peer_model.send(9'h035, 1'b1, 0);
    rchk("ctrl", CTRL_A, 32'h13f7);
    i_scc_peer_model.send(9'h135, 1'b0, 0);
    rchk("ctrl", CTRL_A, 32'h17f7);
    rchk("status", STS_A, 32'h2);
    rchk("rx", RXD_A, 32'h135);
    rchk("rx", RXD_A, 32'h035);
    rchk("status", STS_A, 32'h4);
    apb(1'b1, CTRL_A, 32'h00d7);
    i_scc_peer_model.send(9'h135, 1'b0, 0);
    rchk("ctrl", CTRL_A, 32'h00d7);
    rchk("rx", RXD_A, 32'h135);
    $display("frame test done");
    apb(1'b1, CTRL_A, 32'h0010);
    i_scc_peer_model.send(9'h0a5, 1'b0, 0);
    rchk("ctrl", CTRL_A, 32'h0000);
    i_scc_peer_model.send(9'h05a, 1'b0, 0);
    rchk("rx", RXD_A, 32'h0a5);
    rchk("rx", RXD_A, 32'h000);
    $display("sync test done");
    apb(1'b1, CTRL_A, 32'h0022);
    rxdPin <= 1'b0;
    repeat (2) @(posedge clk);
    chk("rxd", 32'(rxdToCore), 32'h1);
    apb(1'b1, CTRL_A, 32'h0021);
    repeat (2) @(posedge clk);
    chk("rxd", 32'(rxdToCore), 32'h0);
    $display("irda test done");
    apb(1'b1, CTRL_A, 32'h0001);
    abMode <= 3'b011;
    abOdd <= 1'b1;
    abDetectOk <= 1'b1;
    @(posedge clk);
    abDetectOk <= 1'b0;
    rchk("ctrl", CTRL_A, 32'h1003);
    autobaudOn <= 1'b1;
    abren(1'b0);
    rchk("ctrl", CTRL_A, 32'h1003);
    abren(1'b1);
    rchk("ctrl", CTRL_A, 32'h1013);
    $display("autobaud test done");
    // The baud reload value lives outside; only the run, divide-by-3 and fractional select bits are toggled here
    ticks(32'h8001, 6);
    ticks(32'ha001, 4);
    ticks(32'ha801, 3);
    ticks(32'h2001, 0);
    $display("baud test done");
    @(posedge clk);
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    chk("pready", 32'(pready), 32'h0);
    chk("run", 32'(prescaledBaudClk), 32'h0);
    ce <= 1'b1;
    rchk("ctrl", CTRL_A, 32'h2001);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk("ctrl", CTRL_A, 32'h0);
    $display("freeze and reset test done");
    apb(1'b0, 8'h0c, 32'h0);
    chk("slverr", 32'(rerr), 32'h1);
    chk("rdata", rdata, 32'h0);
    $display("unmapped test done");
    stop_test();
  end
endmodule : scc_serial_channel_control_bench
